//--- design/mtc_pkg.sv
// Purpose: shared constants and carriers for the management timestamp clock
// Assumes: 250 MHz controller clock, 32-bit seconds count in ipmi time format
// Notes:   rtc read is a request/answer handshake toward an smbus master engine
package mtc_pkg;
    localparam int unsigned CLK_HZ      = 250_000_000;           // controller clock rate
    localparam int unsigned TICK_SEC    = 1;                     // one count per second
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_SEC;     // cycles per second
    localparam int          TIME_W      = 32;                    // ipmi time width
    localparam logic [TIME_W-1:0] TIME_ZERO = 32'h0000_0000;     // fallback start value

    // command carrier: get sel time, get sdr time, set sel time
    typedef enum logic [1:0] {
        MTC_CMD_NONE,
        MTC_CMD_GET_SEL,
        MTC_CMD_GET_SDR,
        MTC_CMD_SET_SEL
    } mtc_cmd_t;

    typedef struct packed {
        logic              valid;
        mtc_cmd_t          cmd;
        logic [TIME_W-1:0] data;
    } mtc_req_t;

    typedef struct packed {
        logic              valid;
        logic [TIME_W-1:0] data;
    } mtc_rsp_t;
endpackage

//--- design/mtc_timestamp_clock.sv
// Purpose: internal timestamp clock of the management_controller
// Assumes: rtc read done by an external smbus engine on the shared host bus
// Notes:   selftest_done comes from a pin and is synchronised here
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R01: after reset, load the timestamp from the system rtc by a slave read.
// R02: normally read the rtc at once, before the host powers on.
// R03: start no rtc access after host reset until selftest_done asserts.
// R04: abandon a pending rtc read when selftest_done deasserts while the host is powered.
// R05: if selftest is running when ready, start from zero and count up.
// R06: host firmware writes current time after selftest finishes.
// R07: timestamp read by get sel/sdr time, written by set sel time.
// R08: set sel time changes only the internal count, never the rtc.
// R09: on a hung multi-master bus the initiating master performs recovery.
// R10: advance the timestamp by one each second of the controller clock.
module mtc_timestamp_clock
    import mtc_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              nrst,
    // host status pins
    input  wire logic              host_powered,
    input  wire logic              selftest_done,
    // rtc read engine on the host smbus
    output logic                   rtc_rd_req,
    output logic                   rtc_rd_abort,
    input  wire logic              rtc_rd_ack,
    input  wire logic              rtc_rd_err,
    input  wire logic [TIME_W-1:0] rtc_rd_data,
    input  wire logic              bus_hung,
    output logic                   bus_recover,
    // ipmi time commands
    input  wire mtc_req_t          cmd_req,
    output mtc_rsp_t               cmd_rsp,
    // timestamp and state
    output logic [TIME_W-1:0]      stamp,
    output logic                   stamp_from_rtc
);

    typedef enum logic [1:0] {MTC_IDLE, MTC_WAIT, MTC_READ, MTC_RUN} mtc_state_t;

    mtc_state_t         state;
    logic               pwr_s1, pwr_s2, std_s1, std_s2, std_q;
    logic [27:0]        tick_cnt;
    logic               tick;
    logic               fell;
    logic [1:0]         sync_fill;

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for host pins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pwr_s1 <= 1'b0;
            pwr_s2 <= 1'b0;
            std_s1 <= 1'b0;
            std_s2 <= 1'b0;
            std_q  <= 1'b0;
        end else begin
            pwr_s1 <= host_powered;
            pwr_s2 <= pwr_s1;
            std_s1 <= selftest_done;
            std_s2 <= std_s1;
            std_q  <= std_s2;
        end
    end

    assign fell = std_q && !std_s2;  // selftest_done deasserted

    ////////////////////////////////////////////////////////////////////////////
    // synchroniser fill: host pins are trusted once both stages hold them,
    // so a powered host is never mistaken for an off one after reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync_fill <= '0;
        end else begin
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-second enable divider
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt <= '0;
        end else if (tick_cnt == 28'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 28'h0000001;
        end
    end

    assign tick = (tick_cnt == 28'(TICK_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // init sequence: read rtc when host off or selftest done
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state        <= MTC_IDLE;
            rtc_rd_req   <= 1'b0;
            rtc_rd_abort <= 1'b0;
        end else begin
            rtc_rd_abort <= 1'b0;
            unique case (state)
                MTC_IDLE: begin
                    if (!sync_fill[1]) begin
                        state <= MTC_IDLE;           // [R03] reset values are not pin levels
                    end else if (!pwr_s2 || std_s2) begin
                        state      <= MTC_READ;      // [R01] [R02]
                        rtc_rd_req <= 1'b1;
                    end else begin
                        state <= MTC_WAIT;           // [R05]
                    end
                end
                MTC_WAIT: begin
                    if (std_s2) begin
                        state      <= MTC_READ;      // [R03]
                        rtc_rd_req <= 1'b1;
                    end
                end
                MTC_READ: begin
                    if (pwr_s2 && (fell || !std_s2)) begin
                        state        <= MTC_WAIT;    // [R04]
                        rtc_rd_req   <= 1'b0;
                        rtc_rd_abort <= 1'b1;
                    end else if (rtc_rd_ack || rtc_rd_err) begin
                        state      <= MTC_RUN;
                        rtc_rd_req <= 1'b0;
                    end
                end
                MTC_RUN: begin
                    rtc_rd_req <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // recovery only for our own hung transaction
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bus_recover <= 1'b0;
        end else begin
            bus_recover <= bus_hung && rtc_rd_req;  // [R09]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timestamp count
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stamp          <= TIME_ZERO;             // [R05]
            stamp_from_rtc <= 1'b0;
        end else if (cmd_req.valid && cmd_req.cmd == MTC_CMD_SET_SEL) begin
            stamp <= cmd_req.data;                   // [R06] [R08]
        end else if (state == MTC_READ && rtc_rd_ack && !rtc_rd_err
                     && !(pwr_s2 && !std_s2)) begin
            stamp          <= rtc_rd_data;           // [R01]
            stamp_from_rtc <= 1'b1;
        end else if (tick) begin
            stamp <= stamp + 32'h0000_0001;          // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command answers: one cycle after request
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_rsp <= '0;
        end else begin
            cmd_rsp.valid <= cmd_req.valid && cmd_req.cmd != MTC_CMD_NONE;  // [R07]
            cmd_rsp.data  <= (cmd_req.cmd == MTC_CMD_SET_SEL) ? cmd_req.data : stamp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence set_cmd_s;
        cmd_req.valid && cmd_req.cmd == MTC_CMD_SET_SEL;
    endsequence

    no_early_read_a : assert property (@(posedge mclk) disable iff (!nrst) // [R03]
        (state == MTC_WAIT && !std_s2) |=> !rtc_rd_req)
        else $error("rtc read started before selftest done");
    abort_on_fall_a : assert property (@(posedge mclk) disable iff (!nrst) // [R04]
        (state == MTC_READ && pwr_s2 && fell) |=> (rtc_rd_abort && !rtc_rd_req))
        else $error("pending rtc read not abandoned");
    set_loads_a : assert property (@(posedge mclk) disable iff (!nrst) // [R08]
        set_cmd_s |=> (stamp == $past(cmd_req.data)))
        else $error("set sel time did not load stamp");
    get_answer_a : assert property (@(posedge mclk) disable iff (!nrst) // [R07]
        (cmd_req.valid && cmd_req.cmd == MTC_CMD_GET_SEL) |=> (cmd_rsp.valid && cmd_rsp.data == $past(stamp)))
        else $error("get time answer wrong");
    rtc_load_a : assert property (@(posedge mclk) disable iff (!nrst) // [R01]
        (state == MTC_READ && rtc_rd_ack && !rtc_rd_err && !pwr_s2 && !(cmd_req.valid && cmd_req.cmd == MTC_CMD_SET_SEL))
        |=> (stamp == $past(rtc_rd_data) && stamp_from_rtc))
        else $error("rtc value not loaded");
    second_tick_a : assert property (@(posedge mclk) disable iff (!nrst) // [R10]
        (tick && !cmd_req.valid && state != MTC_READ) |=> (stamp == $past(stamp) + 32'h0000_0001))
        else $error("stamp did not advance on second");
    off_read_a : assert property (@(posedge mclk) disable iff (!nrst) // [R02]
        (state == MTC_IDLE && sync_fill[1] && !pwr_s2) |=> (rtc_rd_req && state == MTC_READ))
        else $error("rtc read not started with host off");
    recover_own_a : assert property (@(posedge mclk) disable iff (!nrst) // [R09]
        bus_recover |-> $past(rtc_rd_req))
        else $error("recovery on foreign transaction");
    held_powered_a : assert property (@(posedge mclk) disable iff (!nrst) // [R03]
        (pwr_s2 && !std_s2 && state != MTC_READ) |=> !rtc_rd_req)
        else $error("rtc read started while selftest running");
    abort_pulse_a : assert property (@(posedge mclk) disable iff (!nrst) // [R04]
        rtc_rd_abort |=> !rtc_rd_abort)
        else $error("abort held longer than one cycle");
    set_answer_a : assert property (@(posedge mclk) disable iff (!nrst) // [R07]
        set_cmd_s |=> (cmd_rsp.valid && cmd_rsp.data == $past(cmd_req.data)))
        else $error("set time answer wrong");
    sdr_answer_a : assert property (@(posedge mclk) disable iff (!nrst) // [R07]
        (cmd_req.valid && cmd_req.cmd == MTC_CMD_GET_SDR) |=> (cmd_rsp.valid && cmd_rsp.data == $past(stamp)))
        else $error("get sdr time answer wrong");
    no_answer_a : assert property (@(posedge mclk) disable iff (!nrst) // [R07]
        !(cmd_req.valid && cmd_req.cmd != MTC_CMD_NONE) |=> !cmd_rsp.valid)
        else $error("answer without command");
    req_held_a : assert property (@(posedge mclk) disable iff (!nrst) // [R01]
        (rtc_rd_req && !rtc_rd_ack && !rtc_rd_err && !(pwr_s2 && !std_s2)) |=> rtc_rd_req)
        else $error("rtc read dropped before its answer");
    divider_step_a : assert property (@(posedge mclk) disable iff (!nrst) // [R10]
        !tick |=> (tick_cnt == $past(tick_cnt) + 28'h0000001))
        else $error("second divider skipped a cycle");

endmodule

`default_nettype wire

//--- test/mtc_rtc_model.sv
// Purpose: rtc read engine seen by the timestamp clock
// Assumes: one answer per request, latency set by delay
// Notes:   data line toggles while no answer is given
`timescale 1ns/1ps
`default_nettype none
module mtc_rtc_model import mtc_pkg::*; (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              nrst,
    // read request
    input  wire logic              rtc_rd_req,
    input  wire logic              rtc_rd_abort,
    // behaviour knobs
    input  wire logic [7:0]        delay,
    input  wire logic              fail,
    input  wire logic [TIME_W-1:0] rtc_time,
    // answer
    output logic                   rtc_rd_ack,
    output logic                   rtc_rd_err,
    output logic [TIME_W-1:0]      rtc_rd_data
);
    logic [7:0] wait_cnt;
    ////////////////////////////////////////
    // answer a pending read once; the rtc value is never written
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt <= 8'h00;
            rtc_rd_ack <= 1'b0;
            rtc_rd_err <= 1'b0;
            rtc_rd_data <= 32'h0;
        end else begin
            rtc_rd_ack <= 1'b0;
            rtc_rd_err <= 1'b0;
            rtc_rd_data <= ~rtc_rd_data; // no stale value
            wait_cnt <= wait_cnt + 8'h01;
            if (!rtc_rd_req || rtc_rd_abort || rtc_rd_ack || rtc_rd_err) begin
                wait_cnt <= 8'h00;
            end else if (wait_cnt == delay) begin
                rtc_rd_ack <= !fail;
                rtc_rd_err <= fail;
                rtc_rd_data <= rtc_time;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/test_mtc_timestamp_clock.sv
// Purpose: self-checking bench for the timestamp clock
// Assumes: rtc engine stands in mtc_rtc_model
// Notes:   the one-second tick is too long to reach here
`timescale 1ns/1ps
`default_nettype none
module test_mtc_timestamp_clock import mtc_pkg::*;;
    logic mclk, nrst, host_powered, selftest_done, bus_hung, fail;
    logic rtc_rd_req, rtc_rd_abort, rtc_rd_ack, rtc_rd_err, bus_recover, stamp_from_rtc;
    logic [TIME_W-1:0] rtc_rd_data, stamp, rtc_time, exp_stamp;
    logic [7:0]  delay;
    logic [31:0] lfsr = 32'hbfa2;
    mtc_req_t    cmd_req;
    mtc_rsp_t    cmd_rsp;
    int          n_fail = 0;
    int          total_checks = 0;
    mtc_timestamp_clock u_mtc_timestamp_clock (.mclk, .nrst, .host_powered, .selftest_done, .rtc_rd_req,
        .rtc_rd_abort, .rtc_rd_ack, .rtc_rd_err, .rtc_rd_data, .bus_hung, .bus_recover, .cmd_req,
        .cmd_rsp, .stamp, .stamp_from_rtc);
    mtc_rtc_model u_mtc_rtc_model (.mclk, .nrst, .rtc_rd_req, .rtc_rd_abort, .delay, .fail, .rtc_time,
        .rtc_rd_ack, .rtc_rd_err, .rtc_rd_data);
    ////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (exp !== got) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // bounded wait for a design or rtc model output to go high
    task automatic wait_on(input string what, ref logic sig);
        int i;
        for (i = 0; i < 64 && sig !== 1'b1; i++) cyc(1);
        if (i == 64) begin
            check(what, 32'h1, 32'(sig));
            end_sim();
        end
    endtask
    task automatic do_reset(input logic hp, input logic sd);
        nrst = 1'b0;
        host_powered = hp;
        selftest_done = sd;
        cyc(8);
        nrst = 1'b1;
    endtask
    // one command, answer looked at in the cycle after it is taken
    task automatic send(input mtc_cmd_t c, input logic [31:0] d);
        cmd_req = '{1'b1, c, d};
        cyc(1);
        if (c == MTC_CMD_SET_SEL) exp_stamp = d;
        check("rsp valid", 32'(c != MTC_CMD_NONE), 32'(cmd_rsp.valid));
        if (c != MTC_CMD_NONE) check("rsp data", exp_stamp, cmd_rsp.data);
        check("stamp", exp_stamp, stamp);
        check("no rtc access", 32'h0, 32'(rtc_rd_req));
    endtask
    ////////////////////////////////////////
    // clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // main sequence
    initial begin
        cmd_req = '0;
        bus_hung = 1'b0;
        fail = 1'b0;
        delay = 8'd5;
        rtc_time = next_rand(lfsr);
        do_reset(1'b0, 1'b0);
        wait_on("rtc req", rtc_rd_req);
        bus_hung = 1'b1;
        cyc(1);
        check("recover", 32'h1, 32'(bus_recover));
        bus_hung = 1'b0;
        wait_on("rtc ack", rtc_rd_ack);
        cyc(1);
        exp_stamp = rtc_time;
        check("rtc load", exp_stamp, stamp);
        check("from rtc", 32'h1, 32'(stamp_from_rtc));
        for (int k = 0; k < 16; k++) begin
            lfsr = next_rand(lfsr);
            send(mtc_cmd_t'(k[1:0]), lfsr);
        end
        cmd_req = '0;
        delay = 8'd20;
        do_reset(1'b1, 1'b0);
        exp_stamp = TIME_ZERO;
        cyc(30);
        check("held off", 32'h0, 32'(rtc_rd_req));
        check("zero start", exp_stamp, stamp);
        selftest_done = 1'b1;
        wait_on("req after selftest", rtc_rd_req);
        selftest_done = 1'b0;
        wait_on("abort", rtc_rd_abort);
        cyc(1);
        check("req dropped", 32'h0, 32'(rtc_rd_req));
        fail = 1'b1;
        selftest_done = 1'b1;
        wait_on("rtc err", rtc_rd_err);
        cyc(1);
        check("not from rtc", 32'h0, 32'(stamp_from_rtc));
        send(MTC_CMD_SET_SEL, next_rand(lfsr));
        cmd_req = '0;
        cyc(2);
        end_sim();
    end
endmodule
`default_nettype wire
